/* core/irq_wdog_consts.svh */
// constants of the interrupt aggregation and watchdog unit
// assumes one 50 MHz clock and byte-wide registers at their own addresses
// Behaviour
// R1: mode 00 float idle, low active; 01 high
// R2: mode 10 drive low/high; 11 high/low
// R3: monitor bit sets on masked source event
// R4: clearing mask keeps monitor bit set
// R5: pin active while any monitor bit set
// R6: all monitor bits readable at once; the code reads them one byte per address in the monitor bank
// R7: clear bank write-one clears matching monitor bit
// R8: host clears each serviced monitor bit
// R9: clear-all register bit clears all monitors
// R10: clear-all pin function clears all monitors
// R11: events only on source state change
// R12: 16-bit ms period, zero disables watchdog
// R13: enabled watchdog times out every period
// R14: timeout is source; 32-cycle pin pulse
// R15: restart register bit restarts watchdog period
// R16: restart pin function restarts watchdog period
// R17: lowest-index pin wins for shared function
// R18: config top bit zero means input function
// R19: prescaler makes ms tick; counter reloads
// R20: set wins over simultaneous clear
`ifndef IRQ_WDOG_CONSTS_SVH
`define IRQ_WDOG_CONSTS_SVH

`define ADDR_MODE 16'h0208
`define ADDR_MASK 16'h0209
`define ADDR_WDOG_LO 16'h0211
`define ADDR_WDOG_HI 16'h0212
`define ADDR_RSTF 16'h0a03
`define ADDR_CLR 16'h0a04
`define ADDR_MON 16'h0d02
`define BANK_BYTES 16'h0008
`define RSTF_WDOG_BIT 0
`define RSTF_IRQ_BIT 1
`define MF_DIR_BIT 7
`define MF_IN_WDOG_RST 7'h03
`define MF_IN_IRQ_RST 7'h04
`define MF_OUT_ONE 7'h01
`define MF_OUT_WDOG 7'h03
`define WDOG_SRC_BIT 0
`define WDOG_PULSE_CYC 6'h20
`define CLK_PERIOD_NS 20
`define WDOG_TICK_NS 1000000
`define WDOG_MS_CYCLES (`WDOG_TICK_NS / `CLK_PERIOD_NS)

`endif

/* core/irq_wdog_pkg.sv */
// types of the interrupt aggregation and watchdog unit
// assumes nothing of its surroundings
package irq_wdog_pkg;
   typedef logic [63:0] irq_vec_t;
   typedef enum logic [1:0]
   {
      MODE_OD_LOW = 2'b00,
      MODE_OD_HIGH = 2'b01,
      MODE_PP_HIGH = 2'b10,
      MODE_PP_LOW = 2'b11
   } irq_mode_e;
endpackage

/* core/wdog_timer.sv */
// millisecond watchdog timer with timeout pulse stretcher
// assumes restart is a one-cycle pulse in the clk domain
`timescale 1ns/1ps
`include "irq_wdog_consts.svh"
module wdog_timer #(
   parameter int unsigned MS_CYCLES = `WDOG_MS_CYCLES
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic [15:0] period,
   input wire logic restart,
   output logic timeout,
   output logic pulse_out
);
   logic [15:0] presc_reg;
   logic [15:0] ms_reg;
   logic [5:0] pulse_reg;
   logic off;
   logic tick;
   logic hit;
   assign off = (period == 16'h0000);
   assign tick = (presc_reg == 16'(MS_CYCLES - 1));
   assign hit = tick && (ms_reg == period - 16'h0001);
   assign pulse_out = (pulse_reg != 6'h00);

   always_ff @(posedge clk)
   begin
      if (srst || restart || off || tick) // R12 R15 R19
         presc_reg <= 16'h0000;
      else
         presc_reg <= presc_reg + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (srst || restart || off || hit) // R13 R19
         ms_reg <= 16'h0000;
      else if (tick)
         ms_reg <= ms_reg + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         timeout <= 1'b0;
      else
         timeout <= hit && !restart && !off; // R13
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         pulse_reg <= 6'h00;
      else if (timeout)
         pulse_reg <= `WDOG_PULSE_CYC; // R14
      else if (pulse_reg != 6'h00)
         pulse_reg <= pulse_reg - 6'h01;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wdog_off_a: assert property (off |=> !timeout) // R12
      else $error("watchdog timed out while disabled");
   wdog_restart_a: assert property (restart |=> !timeout && ms_reg == 16'h0000) // R15
      else $error("restart did not reload watchdog");
   pulse_len_a: assert property ($fell(pulse_out) |-> $past(timeout, 33)) // R14
      else $error("watchdog pulse not 32 cycles long");
endmodule

/* core/irq_and_watchdog_unit.sv */
// interrupt monitor bank, interrupt pin driver, pin functions, watchdog
// assumes byte register port and pins synchronous to CLK
`timescale 1ns/1ps
`include "irq_wdog_consts.svh"
module irq_and_watchdog_unit #(
   parameter int unsigned MS_CYCLES = `WDOG_MS_CYCLES
)(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic [15:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire irq_wdog_pkg::irq_vec_t SRC_STATE,
   input wire logic [63:0] MULTI_FUNCTION_CFG,
   input wire logic [7:0] MULTI_FUNCTION_PINS_IN,
   output logic [7:0] MULTI_FUNCTION_PINS_OUT,
   output logic [7:0] MULTI_FUNCTION_PINS_OE_N,
   output logic IRQ_OUT,
   output logic IRQ_OE_N
);
   import irq_wdog_pkg::*;

   irq_mode_e mode_reg;
   irq_vec_t mask_reg;
   irq_vec_t mon_reg;
   irq_vec_t mon_next;
   irq_vec_t src_prev_reg;
   irq_vec_t src_evt;
   irq_vec_t set_vec;
   irq_vec_t clr_vec;
   logic [15:0] period_reg;
   logic primed_reg;
   logic wrst_pin_reg;
   logic irst_pin_reg;
   logic [3:0] wrst_sel;
   logic [3:0] irst_sel;
   logic wrst_lvl;
   logic irst_lvl;
   logic rstf_wr;
   logic wdog_restart;
   logic clr_all;
   logic wdog_timeout;
   logic wdog_pulse;
   logic irq_any;
   logic [7:0] rd_next;

   // byte address inside an eight-byte bank
   function automatic logic in_bank(input logic [15:0] a, input logic [15:0] base);
      return (a >= base) && (a < base + `BANK_BYTES);
   endfunction

   // bit offset of a byte inside a bank
   function automatic logic [5:0] bank_bit(input logic [15:0] a, input logic [15:0] base);
      logic [15:0] d;
      d = a - base;
      return {d[2:0], 3'h0};
   endfunction

   // lowest-index input pin configured for a function
   function automatic logic [3:0] pin_pick(input logic [63:0] cfg, input logic [6:0] code);
      logic [3:0] sel;
      sel = 4'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (!cfg[8 * i + `MF_DIR_BIT] && (cfg[8 * i +: 7] == code)) // R17 R18
            sel = {1'b1, 3'(i)};
      end
      return sel;
   endfunction

   // whether the pin shows the active level in a mode
   function automatic logic pin_active(input irq_mode_e m, input logic o, input logic oe_n);
      logic act;
      act = 1'b0;
      case (m)
         MODE_OD_LOW: act = !oe_n && !o;
         MODE_OD_HIGH: act = !oe_n && o;
         MODE_PP_HIGH: act = o;
         MODE_PP_LOW: act = !o;
         default: act = 1'b0;
      endcase
      return act;
   endfunction

   wdog_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_wdog (
      .clk(CLK),
      .srst(SRST),
      .period(period_reg),
      .restart(wdog_restart),
      .timeout(wdog_timeout),
      .pulse_out(wdog_pulse)
   );

   // register port decode
   assign rstf_wr = REG_WR && (REG_ADDR == `ADDR_RSTF);

   always_comb
   begin
      clr_vec = '0;
      if (REG_WR && in_bank(REG_ADDR, `ADDR_CLR))
         clr_vec = irq_vec_t'(REG_WDATA) << bank_bit(REG_ADDR, `ADDR_CLR); // R7
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         mode_reg <= MODE_OD_LOW;
      else if (REG_WR && (REG_ADDR == `ADDR_MODE))
         mode_reg <= irq_mode_e'(REG_WDATA[1:0]);
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         mask_reg <= '0;
      else if (REG_WR && in_bank(REG_ADDR, `ADDR_MASK))
         mask_reg[bank_bit(REG_ADDR, `ADDR_MASK) +: 8] <= REG_WDATA;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         period_reg <= 16'h0000;
      else if (REG_WR && (REG_ADDR == `ADDR_WDOG_LO))
         period_reg[7:0] <= REG_WDATA; // R12
      else if (REG_WR && (REG_ADDR == `ADDR_WDOG_HI))
         period_reg[15:8] <= REG_WDATA; // R12
   end

   // pin functions, acting on the rising edge of the chosen pin
   assign wrst_sel = pin_pick(MULTI_FUNCTION_CFG, `MF_IN_WDOG_RST);
   assign irst_sel = pin_pick(MULTI_FUNCTION_CFG, `MF_IN_IRQ_RST);
   assign wrst_lvl = wrst_sel[3] && MULTI_FUNCTION_PINS_IN[wrst_sel[2:0]]; // R17
   assign irst_lvl = irst_sel[3] && MULTI_FUNCTION_PINS_IN[irst_sel[2:0]]; // R17

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         wrst_pin_reg <= 1'b0;
         irst_pin_reg <= 1'b0;
      end
      else
      begin
         wrst_pin_reg <= wrst_lvl;
         irst_pin_reg <= irst_lvl;
      end
   end

   assign wdog_restart = (rstf_wr && REG_WDATA[`RSTF_WDOG_BIT]) // R15
      || (wrst_lvl && !wrst_pin_reg); // R16
   assign clr_all = (rstf_wr && REG_WDATA[`RSTF_IRQ_BIT]) // R9
      || (irst_lvl && !irst_pin_reg); // R10

   // change detection on the sources
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         src_prev_reg <= '0;
         primed_reg <= 1'b0;
      end
      else
      begin
         src_prev_reg <= SRC_STATE;
         primed_reg <= 1'b1;
      end
   end

   always_comb
   begin
      src_evt = '0;
      if (primed_reg)
         src_evt = SRC_STATE ^ src_prev_reg; // R11
      src_evt[`WDOG_SRC_BIT] = wdog_timeout; // R14
   end

   assign set_vec = src_evt & mask_reg; // R3

   // monitor bank
   always_comb
   begin
      if (clr_all)
         mon_next = set_vec; // R9 R10 R20
      else
         mon_next = (mon_reg & ~clr_vec) | set_vec; // R4 R7 R20
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         mon_reg <= '0;
      else
         mon_reg <= mon_next; // R3
   end

   assign irq_any = |mon_reg; // R5

   // interrupt pin driver
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         IRQ_OUT <= 1'b0;
         IRQ_OE_N <= 1'b1;
      end
      else
      begin
         case (mode_reg)
            MODE_OD_LOW:
            begin
               IRQ_OUT <= 1'b0; // R1
               IRQ_OE_N <= !irq_any; // R1
            end
            MODE_OD_HIGH:
            begin
               IRQ_OUT <= 1'b1; // R1
               IRQ_OE_N <= !irq_any; // R1
            end
            MODE_PP_HIGH:
            begin
               IRQ_OUT <= irq_any; // R2
               IRQ_OE_N <= 1'b0;
            end
            MODE_PP_LOW:
            begin
               IRQ_OUT <= !irq_any; // R2
               IRQ_OE_N <= 1'b0;
            end
            default:
            begin
               IRQ_OUT <= 1'b0;
               IRQ_OE_N <= 1'b1;
            end
         endcase
      end
   end

   // multifunction pin outputs
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         MULTI_FUNCTION_PINS_OUT <= 8'h00;
         MULTI_FUNCTION_PINS_OE_N <= 8'hff;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            MULTI_FUNCTION_PINS_OE_N[i] <= !MULTI_FUNCTION_CFG[8 * i + `MF_DIR_BIT]; // R18
            MULTI_FUNCTION_PINS_OUT[i] <= MULTI_FUNCTION_CFG[8 * i + `MF_DIR_BIT]
               && (((MULTI_FUNCTION_CFG[8 * i +: 7] == `MF_OUT_WDOG) && wdog_pulse) // R14
               || (MULTI_FUNCTION_CFG[8 * i +: 7] == `MF_OUT_ONE));
         end
      end
   end

   // register read path
   always_comb
   begin
      rd_next = 8'h00;
      if (REG_ADDR == `ADDR_MODE)
         rd_next = {6'h00, mode_reg};
      else if (in_bank(REG_ADDR, `ADDR_MASK))
         rd_next = mask_reg[bank_bit(REG_ADDR, `ADDR_MASK) +: 8];
      else if (REG_ADDR == `ADDR_WDOG_LO)
         rd_next = period_reg[7:0];
      else if (REG_ADDR == `ADDR_WDOG_HI)
         rd_next = period_reg[15:8];
      else if (in_bank(REG_ADDR, `ADDR_MON))
         rd_next = mon_reg[bank_bit(REG_ADDR, `ADDR_MON) +: 8]; // R6
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
         REG_RDATA <= 8'h00;
      else if (REG_RD)
         REG_RDATA <= rd_next;
   end

   // checks
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);

   pin_od_low_a: assert property ((mode_reg == MODE_OD_LOW) |=> // R1
         (IRQ_OE_N == !$past(irq_any)) && !IRQ_OUT)
      else $error("open-drain low mode wrong on interrupt pin");

   pin_od_high_a: assert property ((mode_reg == MODE_OD_HIGH) |=> // R1
         (IRQ_OE_N == !$past(irq_any)) && IRQ_OUT)
      else $error("open-drain high mode wrong on interrupt pin");

   pin_drive_low_a: assert property ((mode_reg == MODE_PP_LOW) |=> // R2
         !IRQ_OE_N && (IRQ_OUT == !$past(irq_any)))
      else $error("driven low mode wrong on interrupt pin");

   pin_drive_a: assert property ((mode_reg == MODE_PP_HIGH) |=> // R2
         !IRQ_OE_N && (IRQ_OUT == $past(irq_any)))
      else $error("driven high mode wrong on interrupt pin");

   pin_or_a: assert property (1'b1 |=> // R5
         pin_active($past(mode_reg), IRQ_OUT, IRQ_OE_N) == $past(irq_any))
      else $error("interrupt pin does not follow monitor OR");

   mon_set_a: assert property ((set_vec != '0) |=> // R3
         ((mon_reg & $past(set_vec)) == $past(set_vec)))
      else $error("masked event did not set monitor bit");

   mon_cause_a: assert property (1'b1 |=> // R3
         ((mon_reg & ~$past(mon_reg) & ~$past(set_vec)) == '0))
      else $error("monitor bit set without masked event");

   mon_hold_a: assert property ((!clr_all && (clr_vec == '0)) |=> // R4
         ((mon_reg & $past(mon_reg)) == $past(mon_reg)))
      else $error("monitor bit lost without a clear");

   clr_one_a: assert property (((clr_vec & ~set_vec) != '0) |=> // R7
         ((mon_reg & $past(clr_vec & ~set_vec)) == '0))
      else $error("clear bank write left monitor bit set");

   clr_all_a: assert property (clr_all |=> ((mon_reg & ~$past(set_vec)) == '0)) // R9
      else $error("clear all left monitor bits set");

   pin_clear_a: assert property ((irst_lvl && !irst_pin_reg) |=> // R10
         ((mon_reg & ~$past(set_vec)) == '0))
      else $error("clear-all pin left monitor bits set");

   edge_only_a: assert property ($stable(SRC_STATE) |-> // R11
         ((src_evt & ~(irq_vec_t'(1) << `WDOG_SRC_BIT)) == '0))
      else $error("event raised without source change");

   wdog_src_a: assert property ((wdog_timeout && mask_reg[`WDOG_SRC_BIT]) |=> // R14
         mon_reg[`WDOG_SRC_BIT])
      else $error("watchdog timeout not seen as source event");

   multi_set_c: cover property ($countones(mon_reg) > 1);
   clr_all_c: cover property (clr_all && irq_any);
   wdog_to_c: cover property (wdog_timeout && mask_reg[`WDOG_SRC_BIT]);
   pin_restart_c: cover property (wrst_lvl && !wrst_pin_reg);
endmodule

/* verification/host_model.sv */
// host model: byte register port master and interrupt service routine
// assumes the unit takes a request at the rising clk edge where a strobe is high
`timescale 1ns/1ps
`include "irq_wdog_consts.svh"
module host_model (
   input wire logic clk,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // released lines show the inverse of the last value
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
   // read every monitor byte and clear what was found set
   task service;
      logic [7:0] d;
      for (int k = 0; k < 8; k++)
      begin
         rd(16'(`ADDR_MON + k), d);
         if (d !== 8'h00)
            wr(16'(`ADDR_CLR + k), d);
      end
   endtask
endmodule

/* verification/tb_irq_and_watchdog_unit.sv */
// self-checking bench of the interrupt and watchdog unit
// assumes host_model in the same library and a short millisecond
`timescale 1ns/1ps
`include "irq_wdog_consts.svh"
module tb_irq_and_watchdog_unit;
   import irq_wdog_pkg::*;
   localparam int unsigned MSC = 20;
   logic clk;
   logic srst;
   logic [15:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic reg_rd;
   logic [7:0] reg_rdata;
   irq_vec_t src;
   logic [63:0] cfg;
   logic [7:0] pin_in;
   logic [7:0] pin_out;
   logic [7:0] pin_oe_n;
   logic irq_out;
   logic irq_oe_n;
   int n_errors;
   int samples_checked;
   irq_and_watchdog_unit #(.MS_CYCLES(MSC)) irq_and_watchdog_unit_inst (
      .CLK(clk), .SRST(srst), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
      .REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .SRC_STATE(src), .MULTI_FUNCTION_CFG(cfg), .MULTI_FUNCTION_PINS_IN(pin_in),
      .MULTI_FUNCTION_PINS_OUT(pin_out), .MULTI_FUNCTION_PINS_OE_N(pin_oe_n),
      .IRQ_OUT(irq_out), .IRQ_OE_N(irq_oe_n)
   );
   host_model host_model_inst (
      .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata)
   );
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e)
      begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task rdchk(input logic [15:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      host_model_inst.rd(a, d);
      chk(nm, e, d);
   endtask
   task flip(input irq_vec_t m);
      @(posedge clk);
      src <= src ^ m;
   endtask
   // expected {enable_n, value} of the interrupt pin
   function automatic logic [1:0] pin_exp(input logic [1:0] m, input logic act);
      case (m)
         2'b00: return act ? 2'b00 : 2'b10;
         2'b01: return act ? 2'b01 : 2'b11;
         2'b10: return {1'b0, act};
         default: return {1'b0, !act};
      endcase
   endfunction
   task pin_loop(input logic act);
      for (int m = 0; m < 4; m++)
      begin
         host_model_inst.wr(`ADDR_MODE, 8'(m));
         repeat (2) @(posedge clk);
         #1;
         chk("irq_pin", {6'h00, pin_exp(2'(m), act)}, {6'h00, irq_oe_n, irq_out});
      end
   endtask
   task wait_pin(input logic lvl, output int n);
      n = 0;
      while (pin_out[3] !== lvl)
      begin
         @(posedge clk);
         #1;
         n++;
         if (n > 300)
         begin
            chk("wdog_pin_wait", 8'h00, 8'hff);
            tally_and_finish();
         end
      end
   endtask
   task t_reset;
      chk("irq_pin_rst", 8'h02, {6'h00, irq_oe_n, irq_out});
      chk("pins_oe_rst", 8'hff, pin_oe_n);
      rdchk(`ADDR_MODE, 8'h00, "mode");
      rdchk(`ADDR_WDOG_LO, 8'h00, "period");
      rdchk(`ADDR_RSTF, 8'h00, "reset_functions");
      rdchk(16'h0300, 8'h00, "unmapped");
      host_model_inst.wr(`ADDR_MON, 8'hff);
      for (int k = 0; k < 8; k++)
      begin
         rdchk(16'(`ADDR_MASK + k), 8'h00, "mask");
         rdchk(16'(`ADDR_MON + k), 8'h00, "monitor");
         rdchk(16'(`ADDR_CLR + k), 8'h00, "clear");
      end
   endtask
   task t_events;
      host_model_inst.wr(`ADDR_MASK, 8'h20);
      host_model_inst.wr(16'(`ADDR_MASK + 1), 8'h02);
      flip(64'h260);
      rdchk(`ADDR_MON, 8'h20, "monitor0");
      rdchk(16'(`ADDR_MON + 1), 8'h02, "monitor1");
      pin_loop(1'b1);
      host_model_inst.wr(`ADDR_MASK, 8'h00);
      rdchk(`ADDR_MON, 8'h20, "monitor_unmask");
      host_model_inst.wr(`ADDR_MASK, 8'h60);
      rdchk(`ADDR_MON, 8'h20, "monitor_late_mask");
      host_model_inst.wr(`ADDR_CLR, 8'h20);
      rdchk(`ADDR_MON, 8'h00, "monitor_clear");
      pin_loop(1'b1);
      host_model_inst.service();
      rdchk(16'(`ADDR_MON + 1), 8'h00, "monitor_service");
      pin_loop(1'b0);
   endtask
   task t_clear_all;
      @(posedge clk);
      cfg <= 64'h0081_0403_8304_0084;
      flip(64'h20);
      pin_in <= 8'h21;
      repeat (3) @(posedge clk);
      #1;
      chk("pins_oe", 8'hb6, pin_oe_n);
      chk("pins_out", 8'h40, pin_out);
      rdchk(`ADDR_MON, 8'h20, "monitor_pin_ignored");
      @(posedge clk);
      pin_in <= 8'h25;
      repeat (2) @(posedge clk);
      pin_in <= 8'h00;
      rdchk(`ADDR_MON, 8'h00, "monitor_pin_clear");
      flip(64'h20);
      host_model_inst.wr(`ADDR_RSTF, 8'h02);
      rdchk(`ADDR_MON, 8'h00, "monitor_reg_clear");
      fork
         host_model_inst.wr(`ADDR_CLR, 8'h20);
         flip(64'h20);
      join
      rdchk(`ADDR_MON, 8'h20, "set_over_clear");
      fork
         host_model_inst.wr(`ADDR_RSTF, 8'h02);
         flip(64'h20);
      join
      rdchk(`ADDR_MON, 8'h20, "set_over_clear_all");
      host_model_inst.wr(`ADDR_RSTF, 8'h02);
      rdchk(`ADDR_MON, 8'h00, "monitor_reg_clear2");
   endtask
   task t_wdog;
      int n;
      int w;
      host_model_inst.wr(`ADDR_MASK, 8'h01);
      host_model_inst.wr(`ADDR_WDOG_LO, 8'h02);
      wait_pin(1'b1, n);
      wait_pin(1'b0, w);
      chk("wdog_pulse_len", 8'h20, 8'(w));
      wait_pin(1'b1, n);
      chk("wdog_interval", 8'(2 * MSC), 8'(w + n));
      rdchk(`ADDR_MON, 8'h01, "wdog_event");
      host_model_inst.wr(`ADDR_CLR, 8'h01);
      for (int i = 0; i < 40; i++)
         host_model_inst.wr(`ADDR_RSTF, 8'h01);
      rdchk(`ADDR_MON, 8'h00, "wdog_reg_restart");
      for (int i = 0; i < 40; i++)
      begin
         @(posedge clk);
         pin_in <= 8'h10;
         @(posedge clk);
         pin_in <= 8'h00;
      end
      rdchk(`ADDR_MON, 8'h00, "wdog_pin_restart");
      host_model_inst.wr(`ADDR_WDOG_LO, 8'h00);
      host_model_inst.wr(`ADDR_CLR, 8'h01);
      repeat (150) @(posedge clk);
      rdchk(`ADDR_MON, 8'h00, "wdog_disabled");
   endtask
   initial
   begin
      n_errors = 0;
      samples_checked = 0;
      srst = 1'b1;
      src = '0;
      cfg = 64'h0;
      pin_in = 8'h00;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_events();
      t_clear_all();
      t_wdog();
      tally_and_finish();
   end
endmodule
